// *** ctm_defs.svh ***
// register offsets, field positions, reset values and timing constants
`ifndef CTM_DEFS_SVH
`define CTM_DEFS_SVH

// register byte addresses
`define CTM_OFS_CMPA_LO   12'h000
`define CTM_OFS_CMPA_HI   12'h004
`define CTM_OFS_CTRL0     12'h008
`define CTM_OFS_CTRL1     12'h00C
`define CTM_OFS_COUNT     12'h010

// timer_control_0 fields
`define CTM_C0_PAUSE      7
`define CTM_C0_CK_HI      6
`define CTM_C0_CK_LO      4
`define CTM_C0_ON         3
`define CTM_C0_RP_HI      2
`define CTM_C0_RP_LO      0

// timer_control_1 fields
`define CTM_C1_MODE_HI    7
`define CTM_C1_MODE_LO    6
`define CTM_C1_PIN_HI     5
`define CTM_C1_PIN_LO     4
`define CTM_C1_OC         3
`define CTM_C1_POL        2
`define CTM_C1_DPX        1
`define CTM_C1_CCLR       0

// reset values
`define CTM_RST_BYTE      8'h00
`define CTM_RST_COUNT     10'h000
`define CTM_RST_WORD      32'h0000_0000

// timing: one period step is 128 timer clocks, code zero means 1024
`define CTM_PERIOD_FULL   11'h400
`define CTM_PRE_SYS4      6'h03
`define CTM_PRE_H16       6'h0F
`define CTM_PRE_H64       6'h3F

`endif

// *** ctm_pkg.sv ***
// types shared by the compact timer design files
package ctm_pkg;

  typedef enum logic [1:0] {
    CTM_MODE_CMP   = 2'h0,
    CTM_MODE_UNDEF = 2'h1,
    CTM_MODE_PWM   = 2'h2,
    CTM_MODE_TMR   = 2'h3
  } ctm_mode_t;

  typedef enum logic [2:0] {
    CTM_ST_OFF  = 3'h1,
    CTM_ST_RUN  = 3'h2,
    CTM_ST_HOLD = 3'h4
  } ctm_state_t;

  typedef enum logic [2:0] {
    CTM_CK_SYS4 = 3'h0,
    CTM_CK_SYS  = 3'h1,
    CTM_CK_H16  = 3'h2,
    CTM_CK_H64  = 3'h3,
    CTM_CK_SUBA = 3'h4,
    CTM_CK_SUBB = 3'h5,
    CTM_CK_EXTR = 3'h6,
    CTM_CK_EXTF = 3'h7
  } ctm_clk_t;

  typedef struct packed {
    logic [5:0] pre;
    logic [1:0] extSync;
    logic       extDly;
    logic [1:0] subSync;
    logic       subDly;
    logic       tick;
  } ctm_tick_state_t;

  typedef struct packed {
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [7:0]  cmpaLo;
    logic [1:0]  cmpaHi;
    logic [7:0]  lowBuf;
    logic [9:0]  count;
    logic        outLvl;
    logic        pin;
    logic        pinOe;
    logic        evtA;
    logic        evtP;
    logic [31:0] rdata;
    ctm_state_t  st;
  } ctm_regs_t;

endpackage

// *** ctm_tick_gen.sv ***
// counter clock source selection, prescaler and pin edge detection
`timescale 1ns/1ps
`include "ctm_defs.svh"

module ctm_tick_gen (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // selection
  input  wire ctm_pkg::ctm_clk_t clkSel,
  // asynchronous clock pins
  input  wire logic              extCountPin,
  input  wire logic              subClk,
  // one-cycle count enable
  output logic                   tick
);
  import ctm_pkg::*;

  ctm_tick_state_t s;
  ctm_tick_state_t next_s;

  logic extRise;
  logic extFall;
  logic subRise;

  // edges taken only from the second synchroniser stage
  assign extRise = s.extSync[1] & ~s.extDly;
  assign extFall = ~s.extSync[1] & s.extDly;
  assign subRise = s.subSync[1] & ~s.subDly;
  assign tick    = s.tick;

  always_comb begin
    next_s         = s;
    next_s.pre     = s.pre + 6'h01;
    next_s.extSync = {s.extSync[0], extCountPin};
    next_s.extDly  = s.extSync[1];
    next_s.subSync = {s.subSync[0], subClk};
    next_s.subDly  = s.subSync[1];
    // high clock taken equal to the system clock
    case (clkSel)
      CTM_CK_SYS4: next_s.tick = (s.pre[1:0] == 2'(`CTM_PRE_SYS4));
      CTM_CK_SYS:  next_s.tick = 1'b1;
      CTM_CK_H16:  next_s.tick = (s.pre[3:0] == 4'(`CTM_PRE_H16));
      CTM_CK_H64:  next_s.tick = (s.pre == `CTM_PRE_H64);
      CTM_CK_SUBA: next_s.tick = subRise;
      CTM_CK_SUBB: next_s.tick = subRise;
      CTM_CK_EXTR: next_s.tick = extRise;
      CTM_CK_EXTF: next_s.tick = extFall;
      default:     next_s.tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

// *** ctm_timer.sv ***
// compact timer unit: apb registers, 10-bit counter, comparators, pin
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "ctm_defs.svh"

// Operation
// - pause bit set holds counter value; clearing resumes from it
// - clock select picks sys/4, sys, high/16, high/64, sub, pin edges
// - on bit rising resets counter to zero; only software count change
// - on bit cleared stops counting; counter keeps residual value
// - compare mode: on bit rising restores pin to initial level
// - period code vs counter bits 9..7, n*128 clocks, zero means 1024
// - period code zero lets counter clear by overflow
// - mode field: 00 compare, 01 undefined, 10 pwm, 11 timer
// - timer mode never drives pin; pin, level, polarity bits unused
// - compare mode A match: 00 hold, 01 low, 10 high, 11 toggle
// - requested level equal to current level shows no change
// - pwm pin field: 00 inactive, 01 active, 10 waveform, 11 undefined
// - level bit: initial level in compare, active level in pwm
// - polarity bit set inverts the driven pin
// - swap bit 0: period code sets period, A duty; 1 swaps them
// - clear source 1 clears on A match, 0 on P match or overflow
// - pwm ignores clear source; period comparator clears counter
// - compare A split: low byte 7..0, high byte 1..0, rest zero
// - 10-bit up counter, comparator A checks all ten bits
// - low byte write goes to buffer, moved on high byte write
module ctm_timer (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // clock pins
  input  wire logic        extCountPin,
  input  wire logic        subClk,
  // timer output pin
  output logic             timerOutPin,
  output logic             timerOutOe,
  // match events
  output logic             matchAEvent,
  output logic             matchPEvent
);
  import ctm_pkg::*;

  ctm_regs_t  s;
  ctm_regs_t  next_s;

  logic       tick;
  logic       setupPh;
  logic       accessPh;
  logic       wrEn;
  logic       mapped;
  logic       onSetNow;
  logic       running;
  logic       pause;
  logic       onBit;
  logic [2:0] period;
  ctm_mode_t  mode;
  logic [1:0] pinFn;
  logic       ocLvl;
  logic       pol;
  logic       dpx;
  logic       cclr;
  logic [9:0] cmpa;
  logic [10:0] incr;
  logic       aHit;
  logic       pHit;
  logic       clearByA;
  logic       clrNow;
  logic [10:0] duty;
  logic       pwmAct;
  logic       rawLvl;

  ctm_tick_gen u_tick (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .clkSel      (ctm_clk_t'(s.ctrl0[`CTM_C0_CK_HI:`CTM_C0_CK_LO])),
    .extCountPin (extCountPin),
    .subClk      (subClk),
    .tick        (tick)
  );

  // field views
  assign pause  = s.ctrl0[`CTM_C0_PAUSE];
  assign onBit  = s.ctrl0[`CTM_C0_ON];
  assign period = s.ctrl0[`CTM_C0_RP_HI:`CTM_C0_RP_LO];
  assign mode   = ctm_mode_t'(s.ctrl1[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO]);
  assign pinFn  = s.ctrl1[`CTM_C1_PIN_HI:`CTM_C1_PIN_LO];
  assign ocLvl  = s.ctrl1[`CTM_C1_OC];
  assign pol    = s.ctrl1[`CTM_C1_POL];
  assign dpx    = s.ctrl1[`CTM_C1_DPX];
  assign cclr   = s.ctrl1[`CTM_C1_CCLR];
  assign cmpa   = {s.cmpaHi, s.cmpaLo};

  // bus decode
  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable;
  assign wrEn     = accessPh & pwrite & pstrb[0];
  assign mapped   = (paddr == `CTM_OFS_CMPA_LO) ||
                    (paddr == `CTM_OFS_CMPA_HI) ||
                    (paddr == `CTM_OFS_CTRL0)   ||
                    (paddr == `CTM_OFS_CTRL1)   ||
                    (paddr == `CTM_OFS_COUNT);
  assign pready   = 1'b1;
  assign pslverr  = accessPh & ~mapped;
  assign prdata   = s.rdata;

  // on bit low to high in this write
  assign onSetNow = wrEn && (paddr == `CTM_OFS_CTRL0) &&
                    pwdata[`CTM_C0_ON] && !onBit;
  assign running  = (s.st == CTM_ST_RUN);

  // comparators on the value the counter is about to take
  assign incr = {1'b0, s.count} + 11'h001;
  assign aHit = (cmpa != `CTM_RST_COUNT) &&
                (incr[9:0] == cmpa) && !incr[10];
  assign pHit = (period != 3'h0) &&
                (incr[9:0] == {period, 7'h00});
  // pwm clears by whichever register sets the period
  assign clearByA = (mode == CTM_MODE_PWM) ? dpx : cclr;
  // code zero never hits: the counter wraps by overflow
  assign clrNow   = clearByA ? aHit : pHit;

  // duty threshold, full duty when it reaches the period
  assign duty = dpx ? ((period == 3'h0) ? `CTM_PERIOD_FULL :
                       {1'b0, period, 7'h00})
                    : {1'b0, cmpa};
  assign pwmAct = ({1'b0, s.count} < duty);

  always_comb begin
    case (mode)
      CTM_MODE_CMP: begin
        rawLvl = s.outLvl;
      end
      CTM_MODE_PWM: begin
        case (pinFn)
          2'h0:    rawLvl = ~ocLvl;
          2'h1:    rawLvl = ocLvl;
          2'h2:    rawLvl = pwmAct ? ocLvl : ~ocLvl;
          default: rawLvl = ~ocLvl;
        endcase
      end
      default: begin
        rawLvl = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_s      = s;
    next_s.evtA = 1'b0;
    next_s.evtP = 1'b0;

    // register writes
    if (wrEn && (paddr == `CTM_OFS_CMPA_LO)) begin
      next_s.lowBuf = pwdata[7:0];
    end else if (wrEn && (paddr == `CTM_OFS_CMPA_HI)) begin
      next_s.cmpaHi = pwdata[1:0];
      next_s.cmpaLo = s.lowBuf;
    end else if (wrEn && (paddr == `CTM_OFS_CTRL0)) begin
      next_s.ctrl0 = pwdata[7:0];
    end else if (wrEn && (paddr == `CTM_OFS_CTRL1)) begin
      next_s.ctrl1 = pwdata[7:0];
    end

    // read data captured in the setup cycle
    if (setupPh && !pwrite) begin
      next_s.rdata = `CTM_RST_WORD;
      if (paddr == `CTM_OFS_CMPA_LO) begin
        next_s.rdata[7:0] = s.lowBuf;
      end else if (paddr == `CTM_OFS_CMPA_HI) begin
        next_s.rdata[1:0] = s.cmpaHi;
        next_s.lowBuf     = s.cmpaLo;
      end else if (paddr == `CTM_OFS_CTRL0) begin
        next_s.rdata[7:0] = s.ctrl0;
      end else if (paddr == `CTM_OFS_CTRL1) begin
        next_s.rdata[7:0] = s.ctrl1;
      end else if (paddr == `CTM_OFS_COUNT) begin
        next_s.rdata[9:0] = s.count;
      end
    end

    // run state from the on and pause bits
    case (s.st)
      CTM_ST_OFF: begin
        if (next_s.ctrl0[`CTM_C0_ON]) begin
          next_s.st = next_s.ctrl0[`CTM_C0_PAUSE] ? CTM_ST_HOLD : CTM_ST_RUN;
        end
      end
      CTM_ST_RUN: begin
        if (!next_s.ctrl0[`CTM_C0_ON]) begin
          next_s.st = CTM_ST_OFF;
        end else if (next_s.ctrl0[`CTM_C0_PAUSE]) begin
          next_s.st = CTM_ST_HOLD;
        end
      end
      CTM_ST_HOLD: begin
        if (!next_s.ctrl0[`CTM_C0_ON]) begin
          next_s.st = CTM_ST_OFF;
        end else if (!next_s.ctrl0[`CTM_C0_PAUSE]) begin
          next_s.st = CTM_ST_RUN;
        end
      end
      default: begin
        next_s.st = CTM_ST_OFF;
      end
    endcase

    // counter
    if (onSetNow) begin
      next_s.count = `CTM_RST_COUNT;
    end else if (running && tick) begin
      next_s.count = clrNow ? `CTM_RST_COUNT : incr[9:0];
      next_s.evtA  = aHit;
      next_s.evtP  = pHit && ((mode == CTM_MODE_PWM) || !cclr);
    end

    // compare mode pin level
    if (onSetNow && (mode == CTM_MODE_CMP)) begin
      next_s.outLvl = ocLvl;
    end else if (running && tick && aHit && (mode == CTM_MODE_CMP)) begin
      case (pinFn)
        2'h1:    next_s.outLvl = 1'b0;
        2'h2:    next_s.outLvl = 1'b1;
        2'h3:    next_s.outLvl = ~s.outLvl;
        default: next_s.outLvl = s.outLvl;
      endcase
    end

    // pin driven only in compare and pwm modes
    next_s.pin   = rawLvl ^ pol;
    next_s.pinOe = (mode == CTM_MODE_CMP) ||
                   (mode == CTM_MODE_PWM);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s    <= '0;
      s.st <= CTM_ST_OFF;
    end else begin
      s <= next_s;
    end
  end

  assign timerOutPin = s.pin;
  assign timerOutOe  = s.pinOe;
  assign matchAEvent = s.evtA;
  assign matchPEvent = s.evtP;

  // checks
  sequence s_hiWrite;
    psel && !penable && pwrite && (paddr == `CTM_OFS_CMPA_HI)
    ##1 psel && penable && pstrb[0];
  endsequence

  sequence s_loWrite;
    psel && !penable && pwrite && (paddr == `CTM_OFS_CMPA_LO)
    ##1 psel && penable && pstrb[0];
  endsequence

  sequence s_hiRead;
    psel && !penable && !pwrite && (paddr == `CTM_OFS_CMPA_HI);
  endsequence

  property p_pauseHold;
    @(posedge clk_sys) disable iff (!arst_n)
      (s.st == CTM_ST_HOLD) |=> $stable(s.count);
  endproperty
  a_pauseHold: assert property (p_pauseHold)
    else $error("counter moved while paused");

  property p_offHold;
    @(posedge clk_sys) disable iff (!arst_n)
      (s.st == CTM_ST_OFF) && !onSetNow |=> $stable(s.count);
  endproperty
  a_offHold: assert property (p_offHold)
    else $error("counter moved while off");

  property p_onClear;
    @(posedge clk_sys) disable iff (!arst_n)
      onSetNow |=> (s.count == `CTM_RST_COUNT) && (s.st != CTM_ST_OFF);
  endproperty
  a_onClear: assert property (p_onClear)
    else $error("counter not zero after switch on");

  property p_cmpInit;
    @(posedge clk_sys) disable iff (!arst_n)
      onSetNow && (mode == CTM_MODE_CMP)
      |=> (s.outLvl == ocLvl) ##1 (s.pin == (ocLvl ^ pol)) || !onBit;
  endproperty
  a_cmpInit: assert property (p_cmpInit)
    else $error("pin not at initial level after switch on");

  property p_timerNoDrive;
    @(posedge clk_sys) disable iff (!arst_n)
      (mode == CTM_MODE_TMR) [*2] |-> !timerOutOe;
  endproperty
  a_timerNoDrive: assert property (p_timerNoDrive)
    else $error("pin driven in timer mode");

  property p_toggle;
    @(posedge clk_sys) disable iff (!arst_n)
      running && tick && aHit && !onSetNow && (mode == CTM_MODE_CMP) &&
      (pinFn == 2'h3) |=> (s.outLvl != $past(s.outLvl));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("compare match did not toggle the pin level");

  property p_pwmForce;
    @(posedge clk_sys) disable iff (!arst_n)
      (mode == CTM_MODE_PWM) && (pinFn == 2'h1)
      |=> timerOutOe && (timerOutPin == ($past(ocLvl) ^ $past(pol)));
  endproperty
  a_pwmForce: assert property (p_pwmForce)
    else $error("pwm forced active level wrong");

  property p_periodClear;
    @(posedge clk_sys) disable iff (!arst_n)
      running && tick && !onSetNow && !clearByA && pHit
      |=> (s.count == `CTM_RST_COUNT) && matchPEvent;
  endproperty
  a_periodClear: assert property (p_periodClear)
    else $error("period match did not clear the counter");

  property p_cmpaClear;
    @(posedge clk_sys) disable iff (!arst_n)
      running && tick && !onSetNow && clearByA && aHit
      |=> (s.count == `CTM_RST_COUNT) && matchAEvent &&
          (!matchPEvent || (mode == CTM_MODE_PWM));
  endproperty
  a_cmpaClear: assert property (p_cmpaClear)
    else $error("compare A match did not clear the counter");

  property p_loOnlyBuf;
    @(posedge clk_sys) disable iff (!arst_n)
      s_loWrite |=> $stable(cmpa) && (s.lowBuf == $past(pwdata[7:0]));
  endproperty
  a_loOnlyBuf: assert property (p_loOnlyBuf)
    else $error("low byte write reached the compare value");

  property p_hiLatch;
    @(posedge clk_sys) disable iff (!arst_n)
      s_hiWrite |=> (s.cmpaLo == $past(s.lowBuf)) &&
                    (s.cmpaHi == $past(pwdata[1:0]));
  endproperty
  a_hiLatch: assert property (p_hiLatch)
    else $error("high byte write did not transfer the buffer");

  property p_hiReserved;
    @(posedge clk_sys) disable iff (!arst_n)
      s_hiRead |=> (prdata[31:2] == 30'h0000_0000);
  endproperty
  a_hiReserved: assert property (p_hiReserved)
    else $error("reserved high byte bits not zero");

endmodule

// *** ctm_pin_partner.sv ***
// pin-side model: external count pin source and timer output wire
`timescale 1ns/1ps

module ctm_pin_partner (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // stimulus control
  input  wire logic edgeEn,
  // timer output pin
  input  wire logic timerOutPin,
  input  wire logic timerOutOe,
  // pin side
  output logic      extCountPin,
  output logic      pinLevel
);
  logic [2:0] div;
  logic       lastLvl;

  // edges every 8 cycles, pin stands still while disabled
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div         <= 3'h0;
      extCountPin <= 1'b0;
      lastLvl     <= 1'b0;
    end else begin
      div <= edgeEn ? div + 3'h1 : 3'h0;
      if (edgeEn && div == 3'h7) extCountPin <= ~extCountPin;
      if (timerOutOe) lastLvl <= timerOutPin;
    end
  end

  // released wire shows the inverse of its last driven level
  assign pinLevel = timerOutOe ? timerOutPin : ~lastLvl;
endmodule

// *** ctm_timer_tb_top.sv ***
// self-checking bench for the compact timer unit
`timescale 1ns/1ps
`include "ctm_defs.svh"

module ctm_timer_tb_top;
  logic        clk_sys = 1'b0;
  logic        arst_n  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [3:0]  pstrb   = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        extCountPin;
  logic        subClk  = 1'b0;
  logic        timerOutPin;
  logic        timerOutOe;
  logic        matchAEvent;
  logic        matchPEvent;
  logic        edgeEn  = 1'b0;
  logic        pinLevel;
  logic [31:0] rd;
  logic        err;
  int          n_fail = 0;
  int          comparisons = 0;
  int          a, b, c, g;
  logic [11:0] regs [4] = '{`CTM_OFS_CMPA_LO, `CTM_OFS_CMPA_HI,
                            `CTM_OFS_CTRL0, `CTM_OFS_CTRL1};
  int          divs [8] = '{4, 1, 16, 64, 16, 16, 16, 16};
  logic [7:0]  pwmC1 [5] = '{8'hA9, 8'hAA, 8'h88, 8'h98, 8'hAC};
  int          pwmA [5]  = '{32, 200, 32, 32, 32};
  int          pwmWin [5] = '{128, 200, 128, 128, 128};
  int          pwmHi [5] = '{32, 128, 0, 128, 96};

  always #25 clk_sys = ~clk_sys;

  // free-running sub clock, one rising edge per 16 cycles
  always begin
    repeat (8) @(posedge clk_sys);
    subClk <= ~subClk;
  end

  ctm_timer u_ctm_timer (
    .clk_sys(clk_sys), .arst_n(arst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extCountPin(extCountPin), .subClk(subClk),
    .timerOutPin(timerOutPin), .timerOutOe(timerOutOe),
    .matchAEvent(matchAEvent), .matchPEvent(matchPEvent)
  );

  ctm_pin_partner u_ctm_pin_partner (
    .clk_sys(clk_sys), .arst_n(arst_n), .edgeEn(edgeEn),
    .timerOutPin(timerOutPin), .timerOutOe(timerOutOe),
    .extCountPin(extCountPin), .pinLevel(pinLevel)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic [11:0] ad, input logic wr,
                     input logic [31:0] wd, input logic [3:0] st);
    int n;
    n = 0;
    @(posedge clk_sys);
    paddr   <= ad;
    psel    <= 1'b1;
    pwrite  <= wr;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) n_fail++;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
    apb(ad, 1'b1, wd, 4'hF);
  endtask

  task automatic rdr(input logic [11:0] ad);
    apb(ad, 1'b0, 32'h0000_0000, 4'hF);
  endtask

  // off first, then mode and pin field, then on
  task automatic cfg(input logic [7:0] c0, input logic [7:0] c1);
    wr(`CTM_OFS_CTRL0, 32'(c0 & 8'hF7));
    wr(`CTM_OFS_CTRL1, 32'(c1));
    wr(`CTM_OFS_CTRL0, 32'(c0 | 8'h08));
  endtask

  task automatic setA(input logic [9:0] v);
    wr(`CTM_OFS_CMPA_LO, 32'(v[7:0]));
    wr(`CTM_OFS_CMPA_HI, 32'(v[9:8]));
  endtask

  task automatic gap(input logic useP, output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while ((useP ? matchPEvent : matchAEvent) !== 1'b1 && n < 1500);
  endtask

  task automatic hiCount(input int win, output int h);
    h = 0;
    repeat (win) begin
      @(negedge clk_sys);
      if (pinLevel === 1'b1) h++;
    end
  endtask

  task automatic wrap_up;
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_sys);
    n_fail++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    foreach (regs[i]) begin
      rdr(regs[i]);
      check(rd, `CTM_RST_WORD);
    end
    rdr(12'h020);
    check(32'(err), 32'd1);
    check(rd, 32'h0000_0000);
    apb(`CTM_OFS_CTRL1, 1'b1, 32'h0000_00A5, 4'h0);
    rdr(`CTM_OFS_CTRL1);
    check(rd, 32'h0000_0000);
    wr(`CTM_OFS_CTRL1, 32'h0000_00A5);
    rdr(`CTM_OFS_CTRL1);
    check(rd, 32'h0000_00A5);
    // compare A byte pairing through the shared buffer
    wr(`CTM_OFS_CMPA_LO, 32'h0000_005A);
    wr(`CTM_OFS_CMPA_HI, 32'h0000_00FF);
    rdr(`CTM_OFS_CMPA_HI);
    check(rd, 32'h0000_0003);
    rdr(`CTM_OFS_CMPA_LO);
    check(rd, 32'h0000_005A);
    wr(`CTM_OFS_CMPA_LO, 32'h0000_0011);
    rdr(`CTM_OFS_CMPA_HI);
    rdr(`CTM_OFS_CMPA_LO);
    check(rd, 32'h0000_005A);
    // pause, off and restart
    cfg(8'h18, 8'hC0);
    repeat (100) @(posedge clk_sys);
    wr(`CTM_OFS_CTRL0, 32'h0000_0098);
    rdr(`CTM_OFS_COUNT);
    a = rd;
    repeat (50) @(posedge clk_sys);
    rdr(`CTM_OFS_COUNT);
    check(rd, 32'(a));
    wr(`CTM_OFS_CTRL0, 32'h0000_0018);
    repeat (20) @(posedge clk_sys);
    rdr(`CTM_OFS_COUNT);
    check(32'(rd > a && rd - a <= 40), 32'd1);
    wr(`CTM_OFS_CTRL0, 32'h0000_0010);
    rdr(`CTM_OFS_COUNT);
    a = rd;
    wr(`CTM_OFS_COUNT, 32'h0000_03FF);
    repeat (50) @(posedge clk_sys);
    rdr(`CTM_OFS_COUNT);
    check(rd, 32'(a));
    wr(`CTM_OFS_CTRL0, 32'h0000_0018);
    rdr(`CTM_OFS_COUNT);
    check(32'(rd <= 8), 32'd1);
    // every clock source over 512 system cycles
    for (int i = 0; i < 8; i++) begin
      edgeEn <= (i >= 6);
      cfg({1'b0, 3'(i), 4'h8}, 8'hC0);
      repeat (512) @(posedge clk_sys);
      rdr(`CTM_OFS_COUNT);
      a = 512 / divs[i];
      check(32'(rd >= a - 3 && rd <= a + 3), 32'd1);
    end
    edgeEn <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      cfg(8'h19, {2'(m), 6'h00});
      repeat (2) @(negedge clk_sys);
      check(32'(timerOutOe), 32'(m == 0 || m == 2));
    end
    // match spacing
    setA(10'h3FF);
    cfg(8'h11, 8'h00);
    gap(1'b1, g);
    gap(1'b1, g);
    check(32'(g), 32'd128);
    cfg(8'h17, 8'h00);
    gap(1'b1, g);
    gap(1'b1, g);
    check(32'(g), 32'd896);
    cfg(8'h10, 8'h00);
    gap(1'b0, g);
    gap(1'b0, g);
    check(32'(g), 32'd1024);
    setA(10'd200);
    cfg(8'h11, 8'h01);
    gap(1'b0, g);
    gap(1'b0, g);
    check(32'(g), 32'd200);
    gap(1'b1, g);
    check(32'(g), 32'd1500);
    // compare output pin per pin field and polarity
    setA(10'd50);
    for (int k = 0; k < 8; k++) begin
      b = k % 4;
      c = k / 4;
      cfg(8'h10, {2'b00, 2'(b), 1'b1, 1'(c), 2'b01});
      repeat (2) @(negedge clk_sys);
      check(32'(timerOutPin), 32'(1 ^ c));
      a = 1;
      for (int j = 0; j < 2; j++) begin
        gap(1'b0, g);
        repeat (2) @(negedge clk_sys);
        a = (b == 0) ? a : (b == 1) ? 0 : (b == 2) ? 1 : 1 - a;
        check(32'(timerOutPin), 32'(a ^ c));
      end
    end
    // pwm duty per pin field, swap and polarity
    for (int i = 0; i < 5; i++) begin
      setA(10'(pwmA[i]));
      cfg(8'h11, pwmC1[i]);
      repeat (300) @(negedge clk_sys);
      hiCount(pwmWin[i], a);
      check(32'(a), 32'(pwmHi[i]));
    end
    cfg(8'h11, 8'hA9);
    gap(1'b1, g);
    gap(1'b1, g);
    check(32'(g), 32'd128);
    wrap_up();
  end
endmodule
